//--- rtl/msi_pkg.sv
package msi_pkg;

  // ----------------------------------------------------------------------
  // speeds and limits
  // ----------------------------------------------------------------------
  localparam int SPD_W = 14;
  typedef logic [SPD_W-1:0] speed_t;
  localparam speed_t NOT_SELECTED    = 14'h270F;
  localparam speed_t SPEED_SET_MAX   = 14'h12C0;
  localparam speed_t SPEED_LIMIT     = 14'h0BB8;
  localparam speed_t HIGH_INIT       = 14'h0BB8;
  localparam speed_t MID_INIT        = 14'h05DC;
  localparam speed_t LOW_INIT        = 14'h012C;
  localparam speed_t INCH_SPEED_INIT = 14'h0096;
  localparam speed_t RAMP_REF_SPEED  = 14'h0BB8;
  localparam speed_t SPEED_ZERO      = 14'h0000;

  // ----------------------------------------------------------------------
  // inching ramp time, in tenths of a second
  // ----------------------------------------------------------------------
  typedef logic [11:0] ramp_t;
  localparam ramp_t RAMP_INIT = 12'h005;
  localparam ramp_t RAMP_MAX  = 12'hE10;

  // ----------------------------------------------------------------------
  // inching target range
  // ----------------------------------------------------------------------
  typedef logic signed [31:0] target_t;
  localparam target_t TARGET_MIN  = 32'hC4653601;
  localparam target_t TARGET_MAX  = 32'h05F5E0FF;
  localparam target_t TARGET_HOME = 32'h00000000;

  // ----------------------------------------------------------------------
  // input terminal function codes
  // ----------------------------------------------------------------------
  typedef logic [7:0] func_t;
  localparam func_t FN_LOW    = 8'h00;
  localparam func_t FN_MID    = 8'h01;
  localparam func_t FN_HIGH   = 8'h02;
  localparam func_t FN_INCH   = 8'h05;
  localparam func_t FN_EXTRA  = 8'h08;
  localparam func_t FN_EXCITE = 8'h17;
  localparam func_t FN_SERVO  = 8'h56;
  localparam func_t FN_NONE   = 8'hFF;

  // ----------------------------------------------------------------------
  // operation modes
  // ----------------------------------------------------------------------
  typedef logic [2:0] opmode_t;
  localparam opmode_t OPM_INIT     = 3'h0;
  localparam opmode_t OPM_COMBINED = 3'h3;
  localparam opmode_t OPM_EXT_COMB = 3'h4;

  // ----------------------------------------------------------------------
  // preset indices
  // ----------------------------------------------------------------------
  typedef logic [3:0] pidx_t;
  localparam pidx_t IDX_NONE   = 4'h0;
  localparam pidx_t IDX_HIGH   = 4'h1;
  localparam pidx_t IDX_MID    = 4'h2;
  localparam pidx_t IDX_LOW    = 4'h3;
  localparam pidx_t IDX_SPEED4 = 4'h4;
  localparam pidx_t IDX_SPEED5 = 4'h5;
  localparam pidx_t IDX_SPEED6 = 4'h6;
  localparam pidx_t IDX_SPEED7 = 4'h7;
  localparam pidx_t IDX_SPEED8 = 4'h8;
  localparam int    N_PRESET   = 15;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  typedef logic [7:0] addr_t;
  localparam addr_t OFS_OP_MODE     = 8'h00;
  localparam addr_t OFS_PARAM_WRITE = 8'h04;
  localparam addr_t OFS_INCH_SPEED  = 8'h08;
  localparam addr_t OFS_INCH_RAMP   = 8'h0C;
  localparam addr_t OFS_CTRL        = 8'h10;
  localparam addr_t OFS_STATUS      = 8'h14;
  localparam addr_t OFS_SPEED       = 8'h18;
  localparam addr_t OFS_TARGET      = 8'h1C;
  localparam logic [2:0] TERM_PAGE   = 3'h1;
  localparam logic [1:0] PRESET_PAGE = 2'h1;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ      = 40_000_000;
  localparam int TICK_US     = 1000;
  localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;

  typedef enum logic [2:0] {SRC_NONE, SRC_ANALOG_FIRST, SRC_ANALOG_SECOND,
                            SRC_PRESET, SRC_INCH} source_t;
  typedef enum logic [1:0] {INCH_IDLE, INCH_RUN, INCH_LIMIT} inch_state_t;

endpackage : msi_pkg

//--- rtl/multi_speed_and_inching_selector.sv
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
// Functional notes
// R1 - high select alone gives high preset
// R2 - middle select alone gives middle preset
// R3 - low select alone gives low preset
// R4 - several selects: lowest ranked one wins
// R5 - speeds 4-15 from combos; 9999 unselected
// R6 - presets 4-15 reset to 9999
// R7 - extra alone, preset 8 unset: low
// R8 - inching, presets, second analog, first analog
// R9 - presets honoured only in modes 3, 4
// R10 - settings 0-4800, output capped 3000
// R11 - preset writes always accepted; code rejects values over 4800 other than 9999
// R12 - position control: preset is maximum speed
// R13 - inching runs at inching speed
// R14 - one inching ramp time, 0-360s
// R15 - inching setting changes apply after stop
// R16 - other side raises servo-on or excitation
// R17 - unhomed: position at enable is home
// R18 - inching target clamped, motion stops
// R19 - function code 8 routes extra select
// R20 - codes 86 servo-on, 23 excitation
// R21 - codes 0,1,2 route low, middle, high
// R22 - start inputs start and stop inching
// R23 - function code 5 routes inching select
// R24 - fixed exhaustive combination table
// R25 - unmatched: next source, else zero
module multi_speed_and_inching_selector #(
  parameter int N_TERMS     = 7,
  parameter int TICK_CYCLES = msi_pkg::TICK_CYCLES
) (
  input  wire logic                 CORE_CLK_IN,
  input  wire logic                 RST_IN,
  input  wire logic                 PSEL_IN,
  input  wire logic                 PENABLE_IN,
  input  wire logic                 PWRITE_IN,
  input  wire msi_pkg::addr_t       PADDR_IN,
  input  wire logic [31:0]          PWDATA_IN,
  output logic      [31:0]          PRDATA_OUT,
  output logic                      PREADY_OUT,
  output logic                      PSLVERR_OUT,
  input  wire logic [N_TERMS-1:0]   TERM_IN,
  input  wire logic                 FORWARD_START_IN,
  input  wire logic                 REVERSE_START_IN,
  input  wire msi_pkg::speed_t      ANALOG_FIRST_SPEED_IN,
  input  wire logic                 ANALOG_FIRST_VALID_IN,
  input  wire msi_pkg::speed_t      ANALOG_SECOND_SPEED_IN,
  input  wire logic                 ANALOG_SECOND_VALID_IN,
  output msi_pkg::speed_t           SPEED_CMD_OUT,
  output msi_pkg::speed_t           MAX_SPEED_OUT,
  output msi_pkg::source_t          SOURCE_OUT,
  output logic                      REVERSE_OUT,
  output msi_pkg::ramp_t            RAMP_TIME_OUT,
  output msi_pkg::speed_t           RAMP_REF_SPEED_OUT,
  output msi_pkg::target_t          INCH_TARGET_OUT,
  output logic                      POSITION_CONTROL_OUT,
  output logic                      INCH_ACTIVE_OUT
);
  import msi_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1);

  if (N_TERMS < 3 || N_TERMS > 8) begin : g_bad_terms
    $error("N_TERMS must be 3 to 8");
  end
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  opmode_t     op_mode;
  logic        write_protect;
  logic        homed;
  speed_t      inch_speed;
  ramp_t       inch_ramp;
  speed_t      inch_speed_applied;
  ramp_t       inch_ramp_applied;
  speed_t      preset [1:N_PRESET];
  func_t       term_fn [N_TERMS];
  inch_state_t inch_state;
  target_t     target;
  logic        pos_ctrl_q;
  logic        clamp_hit;
  logic [TW-1:0] tick_cnt;
  logic        tick;

  logic [N_TERMS-1:0] hit_low, hit_mid, hit_high, hit_extra;
  logic [N_TERMS-1:0] hit_inch, hit_servo, hit_excite;
  logic        inch_select;
  logic        servo_on;
  logic        excitation_enable;
  logic        pos_ctrl;
  logic        multi_ok;
  logic        preset_hit;
  speed_t      preset_val;
  logic        one_start;
  logic signed [32:0] next_target_wide;

  speed_select_if sel ();

  speed_combo_decoder u_decoder (
    .sel (sel.decoder)
  );

  // ----------------------------------------------------------------------
  // terminal function routing
  // ----------------------------------------------------------------------
  for (genvar t = 0; t < N_TERMS; t++) begin : g_term
    assign hit_low[t]    = TERM_IN[t] && (term_fn[t] == FN_LOW);    // see R21
    assign hit_mid[t]    = TERM_IN[t] && (term_fn[t] == FN_MID);    // see R21
    assign hit_high[t]   = TERM_IN[t] && (term_fn[t] == FN_HIGH);   // see R21
    assign hit_extra[t]  = TERM_IN[t] && (term_fn[t] == FN_EXTRA);  // see R19
    assign hit_inch[t]   = TERM_IN[t] && (term_fn[t] == FN_INCH);   // see R23
    assign hit_servo[t]  = TERM_IN[t] && (term_fn[t] == FN_SERVO);  // see R20
    assign hit_excite[t] = TERM_IN[t] && (term_fn[t] == FN_EXCITE); // see R20
  end

  assign sel.low_speed_select    = |hit_low;
  assign sel.middle_speed_select = |hit_mid;
  assign sel.high_speed_select   = |hit_high;
  assign sel.extra_speed_select  = |hit_extra;
  assign inch_select             = |hit_inch;
  assign servo_on                = |hit_servo;
  assign excitation_enable       = |hit_excite;
  assign pos_ctrl                = servo_on | excitation_enable; // see R16

  // ----------------------------------------------------------------------
  // preset resolution
  // ----------------------------------------------------------------------
  assign multi_ok = (op_mode == OPM_COMBINED) || (op_mode == OPM_EXT_COMB); // see R9

  always_comb begin
    preset_hit = 1'b0;
    preset_val = SPEED_ZERO;
    if (multi_ok) begin
      if (sel.primary_ok && preset[sel.primary_idx] != NOT_SELECTED) begin // see R5
        preset_hit = 1'b1;
        preset_val = preset[sel.primary_idx];
      end else if (sel.fallback_ok && preset[sel.fallback_idx] != NOT_SELECTED) begin
        preset_hit = 1'b1; // see R7
        preset_val = preset[sel.fallback_idx];
      end
    end
  end

  function automatic speed_t cap(input speed_t s);
    return (s > SPEED_LIMIT) ? SPEED_LIMIT : s;
  endfunction : cap

  // ----------------------------------------------------------------------
  // position tick divider
  // ----------------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // inching sequence
  // ----------------------------------------------------------------------
  assign one_start = FORWARD_START_IN ^ REVERSE_START_IN;
  assign next_target_wide = REVERSE_OUT ?
      ($signed({target[31], target}) - $signed({19'h00000, inch_speed_applied})) :
      ($signed({target[31], target}) + $signed({19'h00000, inch_speed_applied}));

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      inch_state  <= INCH_IDLE;
      REVERSE_OUT <= 1'b0;
      clamp_hit   <= 1'b0;
    end else begin
      case (inch_state)
        INCH_IDLE: begin
          clamp_hit <= 1'b0;
          if (inch_select && one_start) begin // see R22
            inch_state  <= INCH_RUN;
            REVERSE_OUT <= REVERSE_START_IN;
          end
        end
        INCH_RUN: begin
          if (!inch_select || !one_start) begin // see R22
            inch_state <= INCH_IDLE;
          end else if (pos_ctrl && tick &&
                       (next_target_wide > 33'(TARGET_MAX) ||
                        next_target_wide < 33'(TARGET_MIN))) begin
            inch_state <= INCH_LIMIT; // see R18
            clamp_hit  <= 1'b1;
          end
        end
        INCH_LIMIT: begin
          // held stopped at the limit until the start is released
          if (!inch_select || !one_start) begin
            inch_state <= INCH_IDLE;
          end
        end
        default: inch_state <= INCH_IDLE;
      endcase
    end
  end

  // settings only copied while stopped, so a running jog never jumps
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      inch_speed_applied <= INCH_SPEED_INIT;
      inch_ramp_applied  <= RAMP_INIT;
    end else if (inch_state == INCH_IDLE) begin
      inch_speed_applied <= inch_speed; // see R15
      inch_ramp_applied  <= inch_ramp;  // see R15
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pos_ctrl_q <= 1'b0;
      target     <= TARGET_HOME;
    end else begin
      pos_ctrl_q <= pos_ctrl;
      if (pos_ctrl && !pos_ctrl_q && !homed) begin
        target <= TARGET_HOME; // see R17
      end else if (pos_ctrl && tick && inch_state == INCH_RUN && one_start && inch_select) begin
        if (next_target_wide > 33'(TARGET_MAX)) begin
          target <= TARGET_MAX; // see R18
        end else if (next_target_wide < 33'(TARGET_MIN)) begin
          target <= TARGET_MIN; // see R18
        end else begin
          target <= target_t'(next_target_wide[31:0]);
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // speed source priority
  // ----------------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      SPEED_CMD_OUT <= SPEED_ZERO;
      MAX_SPEED_OUT <= SPEED_LIMIT;
      SOURCE_OUT    <= SRC_NONE;
    end else begin
      MAX_SPEED_OUT <= (pos_ctrl && preset_hit) ? cap(preset_val) : SPEED_LIMIT; // see R12
      if (inch_select) begin
        SOURCE_OUT    <= SRC_INCH; // see R8
        SPEED_CMD_OUT <= (inch_state == INCH_RUN) ?
                         cap(inch_speed_applied) : SPEED_ZERO; // see R13 see R10
      end else if (preset_hit && !pos_ctrl) begin
        SOURCE_OUT    <= SRC_PRESET;
        SPEED_CMD_OUT <= cap(preset_val); // see R10
      end else if (ANALOG_SECOND_VALID_IN) begin
        SOURCE_OUT    <= SRC_ANALOG_SECOND; // see R25
        SPEED_CMD_OUT <= cap(ANALOG_SECOND_SPEED_IN);
      end else if (ANALOG_FIRST_VALID_IN) begin
        SOURCE_OUT    <= SRC_ANALOG_FIRST;
        SPEED_CMD_OUT <= cap(ANALOG_FIRST_SPEED_IN);
      end else begin
        SOURCE_OUT    <= SRC_NONE; // see R25
        SPEED_CMD_OUT <= SPEED_ZERO;
      end
    end
  end

  assign RAMP_TIME_OUT        = inch_ramp_applied; // see R14
  assign RAMP_REF_SPEED_OUT   = RAMP_REF_SPEED;
  assign INCH_TARGET_OUT      = target;
  assign POSITION_CONTROL_OUT = pos_ctrl_q;
  assign INCH_ACTIVE_OUT      = (inch_state != INCH_IDLE);

  // ----------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------
  logic        setup;
  logic        access;
  logic        is_preset;
  logic        is_term;
  pidx_t       p_idx;
  logic [2:0]  t_idx;
  logic        bad_addr;
  logic        bad_write;
  logic [31:0] rd_val;
  speed_t      wr_speed;

  assign setup     = PSEL_IN && !PENABLE_IN;
  assign access    = PSEL_IN && PENABLE_IN;
  assign p_idx     = PADDR_IN[5:2];
  assign t_idx     = PADDR_IN[4:2];
  assign is_preset = (PADDR_IN[7:6] == PRESET_PAGE) && (p_idx != IDX_NONE);
  assign is_term   = (PADDR_IN[7:5] == TERM_PAGE) && (32'(t_idx) < N_TERMS);
  assign wr_speed  = PWDATA_IN[SPD_W-1:0];
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = access && (bad_addr || (PWRITE_IN && bad_write));

  always_comb begin
    bad_addr  = 1'b0;
    bad_write = 1'b0;
    rd_val    = 32'h00000000;
    if (PADDR_IN[1:0] != 2'h0) begin
      bad_addr = 1'b1;
    end else if (is_preset) begin
      rd_val    = 32'(preset[p_idx]);
      bad_write = (PWDATA_IN[31:SPD_W] != '0) ||
                  (wr_speed > SPEED_SET_MAX && wr_speed != NOT_SELECTED); // see R10
    end else if (is_term) begin
      rd_val    = 32'(term_fn[t_idx]);
      bad_write = write_protect || (PWDATA_IN[31:8] != '0);
    end else begin
      case (PADDR_IN)
        OFS_OP_MODE: begin
          rd_val    = 32'(op_mode);
          bad_write = write_protect;
        end
        OFS_PARAM_WRITE: rd_val = 32'(write_protect);
        OFS_INCH_SPEED: begin
          rd_val    = 32'(inch_speed);
          bad_write = write_protect || (PWDATA_IN[31:SPD_W] != '0) ||
                      (wr_speed > SPEED_SET_MAX); // see R10
        end
        OFS_INCH_RAMP: begin
          rd_val    = 32'(inch_ramp);
          bad_write = write_protect || (PWDATA_IN[31:12] != '0) ||
                      (PWDATA_IN[11:0] > RAMP_MAX); // see R14
        end
        OFS_CTRL:   rd_val = 32'(homed);
        OFS_STATUS: rd_val = {20'h00000, clamp_hit, INCH_ACTIVE_OUT, pos_ctrl_q,
                              inch_select, sel.extra_speed_select,
                              sel.high_speed_select, sel.middle_speed_select,
                              sel.low_speed_select, 1'b0, SOURCE_OUT};
        OFS_SPEED: begin
          rd_val    = 32'(SPEED_CMD_OUT);
          bad_write = 1'b1;
        end
        OFS_TARGET: begin
          rd_val    = target;
          bad_write = 1'b1;
        end
        default: bad_addr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      PRDATA_OUT <= 32'h00000000;
    end else if (setup && !PWRITE_IN) begin
      PRDATA_OUT <= rd_val;
    end
  end

  // presets are open to writes whatever the protect bit says
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      preset[IDX_HIGH] <= HIGH_INIT; // see R1
      preset[IDX_MID]  <= MID_INIT;  // see R2
      preset[IDX_LOW]  <= LOW_INIT;  // see R3
      for (int i = 4; i <= N_PRESET; i++) begin
        preset[i] <= NOT_SELECTED; // see R6
      end
    end else if (access && PWRITE_IN && is_preset && !bad_write && !bad_addr) begin
      preset[p_idx] <= wr_speed; // see R11
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      for (int i = 0; i < N_TERMS; i++) begin
        term_fn[i] <= (i == 0) ? FN_LOW : (i == 1) ? FN_MID : (i == 2) ? FN_HIGH : FN_NONE;
      end
    end else if (access && PWRITE_IN && is_term && !bad_write && !bad_addr) begin
      term_fn[t_idx] <= PWDATA_IN[7:0];
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      op_mode       <= OPM_INIT;
      write_protect <= 1'b0;
      homed         <= 1'b0;
      inch_speed    <= INCH_SPEED_INIT; // see R13
      inch_ramp     <= RAMP_INIT;       // see R14
    end else if (access && PWRITE_IN && !bad_write && !bad_addr && !is_preset && !is_term) begin
      case (PADDR_IN)
        OFS_OP_MODE:     op_mode       <= PWDATA_IN[2:0];
        OFS_PARAM_WRITE: write_protect <= PWDATA_IN[0];
        OFS_INCH_SPEED:  inch_speed    <= wr_speed;
        OFS_INCH_RAMP:   inch_ramp     <= PWDATA_IN[11:0];
        OFS_CTRL:        homed         <= PWDATA_IN[0];
        default:         ;
      endcase
    end
  end

endmodule : multi_speed_and_inching_selector

//--- rtl/speed_combo_decoder.sv
`timescale 1ns/10ps
module speed_combo_decoder (
  speed_select_if.decoder sel
);
  import msi_pkg::*;

  logic hi;
  logic mi;
  logic lo;
  logic two_or_more;

  assign hi = sel.high_speed_select;
  assign mi = sel.middle_speed_select;
  assign lo = sel.low_speed_select;
  assign two_or_more = (hi & mi) | (hi & lo) | (mi & lo);

  always_comb begin
    sel.primary_ok   = 1'b0;
    sel.primary_idx  = IDX_NONE;
    sel.fallback_ok  = 1'b0;
    sel.fallback_idx = IDX_NONE;
    if (sel.extra_speed_select) begin
      // extra select on: speeds 8..15 straight from the three selects
      sel.primary_ok  = 1'b1; // see R5
      sel.primary_idx = {1'b1, hi, mi, lo}; // see R24
      if ({1'b1, hi, mi, lo} == IDX_SPEED8) begin
        sel.fallback_ok  = 1'b1; // see R7
        sel.fallback_idx = IDX_LOW;
      end
    end else begin
      if (two_or_more) begin
        sel.primary_ok = 1'b1; // see R24
        case ({hi, mi, lo})
          3'b110:  sel.primary_idx = IDX_SPEED4;
          3'b101:  sel.primary_idx = IDX_SPEED5;
          3'b011:  sel.primary_idx = IDX_SPEED6;
          default: sel.primary_idx = IDX_SPEED7;
        endcase
      end
      // unconfigured combinations drop back to lowest active select
      sel.fallback_ok = hi | mi | lo;
      if (lo) begin
        sel.fallback_idx = IDX_LOW; // see R3 see R4
      end else if (mi) begin
        sel.fallback_idx = IDX_MID; // see R2 see R4
      end else if (hi) begin
        sel.fallback_idx = IDX_HIGH; // see R1
      end
    end
  end

endmodule : speed_combo_decoder

//--- rtl/speed_select_if.sv
`timescale 1ns/10ps
interface speed_select_if;
  import msi_pkg::*;
  logic  high_speed_select;
  logic  middle_speed_select;
  logic  low_speed_select;
  logic  extra_speed_select;
  pidx_t primary_idx;
  logic  primary_ok;
  pidx_t fallback_idx;
  logic  fallback_ok;

  modport decoder (input  high_speed_select, middle_speed_select,
                          low_speed_select, extra_speed_select,
                   output primary_idx, primary_ok, fallback_idx, fallback_ok);
  modport user    (output high_speed_select, middle_speed_select,
                          low_speed_select, extra_speed_select,
                   input  primary_idx, primary_ok, fallback_idx, fallback_ok);
endinterface : speed_select_if

//--- test/contact_bank.sv
`timescale 1ns/10ps
module contact_bank (
  input  wire logic       clk_in,
  input  wire logic [8:0] want_in,
  output logic      [6:0] term_out,
  output logic            fwd_out,
  output logic            rev_out
);
  // registered on the clock edge, so contacts change at the edge where the selector samples their old values
  always @(posedge clk_in) {rev_out, fwd_out, term_out} <= want_in;
endmodule : contact_bank

//--- test/sel_monitor.sv
`timescale 1ns/10ps
module sel_monitor (
  input wire logic             CORE_CLK_IN,
  input wire logic             RST_IN,
  input wire logic             PSEL_IN,
  input wire logic             PENABLE_IN,
  input wire logic             PSLVERR_OUT,
  input wire logic             FORWARD_START_IN,
  input wire logic             REVERSE_START_IN,
  input wire msi_pkg::speed_t  SPEED_CMD_OUT,
  input wire msi_pkg::speed_t  MAX_SPEED_OUT,
  input wire msi_pkg::source_t SOURCE_OUT,
  input wire msi_pkg::ramp_t   RAMP_TIME_OUT,
  input wire msi_pkg::target_t INCH_TARGET_OUT,
  input wire logic             INCH_ACTIVE_OUT
);
  import msi_pkg::*;
  // ------
  // rules
  // ------
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  a_err_access: assert property (!(PSEL_IN && PENABLE_IN) |-> !PSLVERR_OUT)
    else $error("error outside access");
  a_speed_cap: assert property (SPEED_CMD_OUT <= SPEED_LIMIT) else $error("speed cap");
  a_max_cap: assert property (MAX_SPEED_OUT <= SPEED_LIMIT) else $error("max cap");
  a_target_range: assert property (INCH_TARGET_OUT >= TARGET_MIN &&
    INCH_TARGET_OUT <= TARGET_MAX) else $error("target range");
  a_both_stop: assert property (FORWARD_START_IN && REVERSE_START_IN |=> !INCH_ACTIVE_OUT)
    else $error("both starts");
  a_no_start: assert property (!FORWARD_START_IN && !REVERSE_START_IN |=> !INCH_ACTIVE_OUT)
    else $error("no start");
  a_ramp_hold: assert property (INCH_ACTIVE_OUT && $past(INCH_ACTIVE_OUT)
    |-> $stable(RAMP_TIME_OUT)) else $error("ramp changed");
  a_idle_zero: assert property (SOURCE_OUT == SRC_NONE |-> SPEED_CMD_OUT == SPEED_ZERO)
    else $error("idle speed");
endmodule : sel_monitor
bind multi_speed_and_inching_selector sel_monitor u_sel_monitor (.*);

//--- test/tb.sv
`timescale 1ns/10ps
module tb;
  import msi_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, a2v = 1'b1;
  logic        rdy, serr, fwd, rev, rv, pc;
  addr_t       padr = 8'h00;
  logic [31:0] pwd = 32'h0, prd, rdat;
  logic [8:0]  want = 9'h000;
  logic [6:0]  term;
  speed_t      spd;
  source_t     src;
  speed_t      mx, rrs;
  target_t     tgt;
  int          fail_count = 0, compares = 0;
  initial forever #12.5 clk = ~clk;
  contact_bank u_contact_bank (.clk_in(clk), .want_in(want), .term_out(term), .fwd_out(fwd),
    .rev_out(rev));
  multi_speed_and_inching_selector #(.TICK_CYCLES(2)) u_multi_speed_and_inching_selector (
    .CORE_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(padr), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(rdy), .PSLVERR_OUT(serr),
    .TERM_IN(term), .FORWARD_START_IN(fwd), .REVERSE_START_IN(rev),
    .ANALOG_FIRST_SPEED_IN(14'h0064), .ANALOG_FIRST_VALID_IN(1'b1),
    .ANALOG_SECOND_SPEED_IN(14'h00C8), .ANALOG_SECOND_VALID_IN(a2v), .SPEED_CMD_OUT(spd),
    .MAX_SPEED_OUT(mx), .SOURCE_OUT(src), .REVERSE_OUT(rv), .RAMP_TIME_OUT(),
    .RAMP_REF_SPEED_OUT(rrs), .INCH_TARGET_OUT(tgt), .POSITION_CONTROL_OUT(pc),
    .INCH_ACTIVE_OUT());
  // ------
  // tasks
  // ------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic w, input addr_t a, input logic [31:0] d, input logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    padr <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rdat = prd;
    psel <= 1'b0;
    pen  <= 1'b0;
    chk(serr, e);
  endtask : wr
  task automatic rd(input addr_t a, input logic [31:0] x);
    wr(1'b0, a, 32'h0, 1'b0);
    chk(rdat, x);
  endtask : rd
  // contacts pass the bank register, then the selector register
  task automatic sp(input logic [8:0] w, input speed_t x);
    want <= w;
    repeat (4) @(posedge clk);
    chk(spd, x);
  endtask : sp
  task automatic final_report;
    $display("compares=%0d mismatches=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  initial begin
    #1200000;
    fail_count++;
    final_report();
  end
  // ------
  // tests
  // ------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 1; i < 16; i++) rd(8'(8'h40 + 4 * i), i == 1 ? HIGH_INIT : i == 2 ? MID_INIT :
      i == 3 ? LOW_INIT : NOT_SELECTED);
    rd(OFS_INCH_SPEED, INCH_SPEED_INIT);
    sp(9'h004, 14'h00C8);
    wr(1'b1, OFS_OP_MODE, 32'h3, 1'b0);
    sp(9'h004, HIGH_INIT);
    sp(9'h002, MID_INIT);
    sp(9'h001, LOW_INIT);
    sp(9'h006, MID_INIT);
    sp(9'h007, LOW_INIT);
    a2v <= 1'b0;
    sp(9'h000, 14'h0064);
    $display("test presets done");
    wr(1'b1, 8'h2C, FN_EXTRA, 1'b0);
    sp(9'h008, LOW_INIT);
    wr(1'b1, 8'h60, 32'h3E8, 1'b0);
    sp(9'h008, 14'h03E8);
    wr(1'b1, 8'h50, 32'hFA0, 1'b0);
    sp(9'h006, SPEED_LIMIT);
    wr(1'b1, 8'h50, 32'h1388, 1'b1);
    wr(1'b1, OFS_PARAM_WRITE, 32'h1, 1'b0);
    wr(1'b1, 8'h50, 32'h270F, 1'b0);
    sp(9'h006, MID_INIT);
    wr(1'b1, OFS_PARAM_WRITE, 32'h0, 1'b0);
    $display("test combinations done");
    wr(1'b1, 8'h30, FN_INCH, 1'b0);
    sp(9'h090, INCH_SPEED_INIT);
    wr(1'b1, OFS_INCH_SPEED, 32'h12C, 1'b0);
    sp(9'h090, INCH_SPEED_INIT);
    sp(9'h010, SPEED_ZERO);
    sp(9'h094, 14'h012C);
    chk(src, SRC_INCH);
    sp(9'h190, SPEED_ZERO);
    sp(9'h110, 14'h012C);
    chk(rv, 1'b1);
    $display("test inching done");
    wr(1'b1, 8'h34, FN_SERVO, 1'b0);
    sp(9'h022, 14'h0064);
    chk(mx, MID_INIT);
    chk(pc, 1'b1);
    chk(tgt, TARGET_HOME);
    chk(rrs, RAMP_REF_SPEED);
    wr(1'b1, OFS_INCH_SPEED, 32'h12C0, 1'b0);
    sp(9'h0B0, SPEED_LIMIT);
    chk(rv, 1'b0);
    repeat (42000) @(posedge clk);
    chk(tgt, TARGET_MAX);
    chk(spd, SPEED_ZERO);
    $display("test position done");
    final_report();
  end
endmodule : tb
